// *** rtl/canmd_pkg.sv ***
// constants and types shared by the can mode-control block
package canmd_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;

   // register byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STAT = 8'h04;
   localparam logic [7:0] ADDR_WAKE = 8'h08;

   // control register fields
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_SLEEP_BIT = 2;
   localparam int CTRL_TEST_LSB = 3;

   // status register fields
   localparam int STAT_MODE_LSB = 0;
   localparam int STAT_SLEEP_BIT = 2;
   localparam int STAT_TEST_LSB = 3;
   localparam int STAT_RX_BIT = 5;

   // wakeup interrupt control fields
   localparam int WAKE_EN_BIT = 0;
   localparam int WAKE_PEND_BIT = 1;

   // mode request / status encodings
   localparam logic [1:0] MODE_OPERATE = 2'h0;
   localparam logic [1:0] MODE_RESET = 2'h1;
   localparam logic [1:0] MODE_HALT = 2'h2;

   // test mode select encodings
   localparam logic [1:0] TEST_NONE = 2'h0;
   localparam logic [1:0] TEST_LISTEN = 2'h1;
   localparam logic [1:0] TEST_EXT_LOOP = 2'h2;
   localparam logic [1:0] TEST_INT_LOOP = 2'h3;

   localparam logic RECESSIVE = 1'b1;
   localparam logic [7:0] DATA_ZERO = 8'h00;

   typedef enum logic [1:0] {
      CANMD_ST_RESET,
      CANMD_ST_HALT,
      CANMD_ST_OPERATE,
      CANMD_ST_SLEEP
   } canmd_mode_t;
endpackage

// *** rtl/canmd_sync.sv ***
// three-stage synchroniser whose output moves only when stages two and three agree
`timescale 1ns/1ps
module canmd_sync
   import canmd_pkg::*;
(
   input wire logic mclk, // module clock
   input wire logic rst, // async reset, active high
   input wire logic async_in, // pin from outside the clock domain
   output logic level // filtered, synchronised level
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
   } canmd_sync_t;

   canmd_sync_t st_q, st_d;

   always_comb begin
      st_d = st_q;
      st_d.s1 = async_in;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      if (st_q.s2 == st_q.s3) begin
         st_d.lvl = st_q.s3;
      end
   end

   // idle bus is recessive, so the chain resets to that level
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_q <= '{s1: RECESSIVE, s2: RECESSIVE, s3: RECESSIVE, lvl: RECESSIVE};
      end else begin
         st_q <= st_d;
      end
   end

   assign level = st_q.lvl;
endmodule

// *** rtl/canmd_route.sv ***
// test-mode routing between protocol engine, transmit pin and receive pin
`timescale 1ns/1ps
module canmd_route
   import canmd_pkg::*;
(
   input wire logic [1:0] test_mode_select, // active test mode
   input wire logic asleep, // channel is in sleep
   input wire logic eng_tx, // bit the engine wants to send, 1 = recessive
   input wire logic rx_level, // synchronised receive pin
   output logic pin_tx_d, // next level of the transmit pin
   output logic eng_rx_d, // next level seen by the engine
   output logic self_ack, // engine supplies its own acknowledge
   output logic tx_allow // transmission start permitted
);
   always_comb begin
      pin_tx_d = eng_tx;
      eng_rx_d = rx_level;
      self_ack = 1'b0;
      tx_allow = 1'b1;
      unique case (test_mode_select)
         TEST_NONE: begin
         end
         TEST_LISTEN: begin
            pin_tx_d = RECESSIVE;
            tx_allow = 1'b0;
            eng_rx_d = rx_level & eng_tx;
         end
         TEST_EXT_LOOP: begin
            self_ack = 1'b1;
         end
         TEST_INT_LOOP: begin
            pin_tx_d = RECESSIVE;
            eng_rx_d = eng_tx;
            self_ack = 1'b1;
         end
      endcase
      // sleeping channel neither drives the bus nor starts frames
      if (asleep) begin
         pin_tx_d = RECESSIVE;
         tx_allow = 1'b0;
      end
   end
endmodule

// *** rtl/canmd_top.sv ***
// can channel mode control: sleep, wakeup and test-mode routing
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ps
module canmd_top
   import canmd_pkg::*;
(
   input wire logic mclk, // ungated module clock
   input wire logic rst, // async reset, active high
   input wire logic [ADDR_W-1:0] reg_addr, // register byte address
   input wire logic [DATA_W-1:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   output logic [DATA_W-1:0] reg_rdata, // read data, cycle after strobe
   input wire logic can_receive_pin, // receive pin from transceiver
   output logic can_transmit_pin, // transmit pin to transceiver
   input wire logic eng_tx, // engine transmit bit, 1 = recessive
   input wire logic eng_tx_req, // engine asks to start a frame
   output logic eng_rx, // receive bit presented to the engine
   output logic eng_tx_start, // frame start granted
   output logic eng_self_ack, // engine generates its own acknowledge
   output logic eng_run, // engine may take part in bus traffic
   output logic eng_halted, // engine held in reset or halt
   output logic core_clk_en, // enable for the gated controller clock
   output logic wakeup_irq // wakeup interrupt request
);
   typedef struct packed {
      canmd_mode_t mode;
      canmd_mode_t prev;
      logic [1:0] test;
      logic wake_en;
      logic wake_pend;
      logic rx_prev;
      logic pin_tx;
      logic eng_rx;
      logic [DATA_W-1:0] rdata;
   } canmd_state_t;

   canmd_state_t st_q, st_d;

   logic rx_level;
   logic pin_tx_d;
   logic eng_rx_d;
   logic self_ack;
   logic tx_allow;
   logic asleep;
   logic wr_ctrl;
   logic wr_wake;
   logic [1:0] req_mode;
   logic req_sleep;
   logic rx_fall;
   logic [1:0] mode_code;

   // the detector sits on the ungated clock so it still sees the pin in sleep
   canmd_sync i_canmd_sync (
      .mclk(mclk),
      .rst(rst),
      .async_in(can_receive_pin),
      .level(rx_level)
   );

   canmd_route i_canmd_route (
      .test_mode_select(st_q.test),
      .asleep(asleep),
      .eng_tx(eng_tx),
      .rx_level(rx_level),
      .pin_tx_d(pin_tx_d),
      .eng_rx_d(eng_rx_d),
      .self_ack(self_ack),
      .tx_allow(tx_allow)
   );

   assign asleep = (st_q.mode == CANMD_ST_SLEEP);
   assign wr_ctrl = reg_wr && (reg_addr == ADDR_CTRL);
   assign wr_wake = reg_wr && (reg_addr == ADDR_WAKE);
   assign req_mode = reg_wdata[CTRL_MODE_LSB +: 2];
   assign req_sleep = reg_wdata[CTRL_SLEEP_BIT];
   assign rx_fall = st_q.rx_prev && !rx_level;

   always_comb begin
      unique case (st_q.mode)
         CANMD_ST_RESET: mode_code = MODE_RESET;
         CANMD_ST_HALT: mode_code = MODE_HALT;
         CANMD_ST_OPERATE: mode_code = MODE_OPERATE;
         CANMD_ST_SLEEP: mode_code = (st_q.prev == CANMD_ST_HALT) ? MODE_HALT : MODE_RESET;
      endcase
   end

   always_comb begin
      st_d = st_q;
      st_d.rx_prev = rx_level;
      st_d.pin_tx = pin_tx_d;
      st_d.eng_rx = asleep ? RECESSIVE : eng_rx_d;
      st_d.rdata = DATA_ZERO;

      // mode sequencing
      if (wr_ctrl) begin
         unique case (st_q.mode)
            CANMD_ST_SLEEP: begin
               // only a sleep cancel is honoured while asleep
               if (!req_sleep) begin
                  st_d.mode = st_q.prev;
               end
            end
            CANMD_ST_OPERATE: begin
               // a sleep request straight from operation is ignored
               if (req_mode == MODE_RESET) begin
                  st_d.mode = CANMD_ST_RESET;
               end else if (req_mode == MODE_HALT) begin
                  st_d.mode = CANMD_ST_HALT;
               end
            end
            CANMD_ST_RESET, CANMD_ST_HALT: begin
               if (req_sleep) begin
                  st_d.prev = st_q.mode;
                  st_d.mode = CANMD_ST_SLEEP;
               end else if (req_mode == MODE_OPERATE) begin
                  st_d.mode = CANMD_ST_OPERATE;
               end else if (req_mode == MODE_RESET) begin
                  st_d.mode = CANMD_ST_RESET;
               end else if (req_mode == MODE_HALT) begin
                  st_d.mode = CANMD_ST_HALT;
               end
            end
         endcase
         // test mode is latched only in halt, so a live frame never sees it change
         if (st_q.mode == CANMD_ST_HALT) begin
            st_d.test = reg_wdata[CTRL_TEST_LSB +: 2];
         end
      end

      // wakeup interrupt control: enable writable, pending is write-one-to-clear
      if (wr_wake) begin
         st_d.wake_en = reg_wdata[WAKE_EN_BIT];
         if (reg_wdata[WAKE_PEND_BIT]) begin
            st_d.wake_pend = 1'b0;
         end
      end
      // set after clear so an edge in the clearing cycle is kept
      if (asleep && rx_fall && st_q.wake_en) begin
         st_d.wake_pend = 1'b1;
      end

      // read data for the next cycle
      if (reg_rd) begin
         if (reg_addr == ADDR_CTRL) begin
            st_d.rdata[CTRL_MODE_LSB +: 2] = mode_code;
            st_d.rdata[CTRL_SLEEP_BIT] = asleep;
            st_d.rdata[CTRL_TEST_LSB +: 2] = st_q.test;
         end else if (reg_addr == ADDR_STAT) begin
            st_d.rdata[STAT_MODE_LSB +: 2] = mode_code;
            st_d.rdata[STAT_SLEEP_BIT] = asleep;
            st_d.rdata[STAT_TEST_LSB +: 2] = st_q.test;
            st_d.rdata[STAT_RX_BIT] = rx_level;
         end else if (reg_addr == ADDR_WAKE) begin
            st_d.rdata[WAKE_EN_BIT] = st_q.wake_en;
            st_d.rdata[WAKE_PEND_BIT] = st_q.wake_pend;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_q.mode <= CANMD_ST_RESET;
         st_q.prev <= CANMD_ST_RESET;
         st_q.test <= TEST_NONE;
         st_q.wake_en <= 1'b0;
         st_q.wake_pend <= 1'b0;
         st_q.rx_prev <= RECESSIVE;
         st_q.pin_tx <= RECESSIVE;
         st_q.eng_rx <= RECESSIVE;
         st_q.rdata <= DATA_ZERO;
      end else begin
         st_q <= st_d;
      end
   end

   assign reg_rdata = st_q.rdata;
   assign can_transmit_pin = st_q.pin_tx;
   assign eng_rx = st_q.eng_rx;
   // a request in listen-only is software misuse; it is simply never granted
   assign eng_tx_start = eng_tx_req && tx_allow && (st_q.mode == CANMD_ST_OPERATE);
   assign eng_self_ack = self_ack;
   assign eng_run = (st_q.mode == CANMD_ST_OPERATE);
   assign eng_halted = (st_q.mode == CANMD_ST_RESET) || (st_q.mode == CANMD_ST_HALT);
   assign core_clk_en = !asleep;
   assign wakeup_irq = st_q.wake_pend && st_q.wake_en;
endmodule

// *** bench/canmd_sva.sv ***
// concurrent checks on the mode-control ports
`timescale 1ns/1ps
module canmd_sva
   import canmd_pkg::*;
(
   input logic mclk, // clock
   input logic rst, // reset
   input logic [ADDR_W-1:0] reg_addr, // address
   input logic [DATA_W-1:0] reg_wdata, // write data
   input logic reg_wr, // write strobe
   input logic reg_rd, // read strobe
   input logic [DATA_W-1:0] reg_rdata, // read data
   input logic can_transmit_pin, // tx pin
   input logic eng_tx_req, // start request
   input logic eng_tx_start, // start grant
   input logic eng_run, // operate
   input logic eng_halted, // reset or halt
   input logic core_clk_en, // clock enable
   input logic wakeup_irq // wakeup request
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   logic ctl_w;
   logic wake_w;
   assign ctl_w = reg_wr && reg_addr == ADDR_CTRL;
   assign wake_w = reg_wr && reg_addr == ADDR_WAKE;
   AST_SLEEP_IDLE: assert property (!core_clk_en |-> !eng_tx_start && !eng_run)
      else $error("activity while asleep");
   AST_SLEEP_PIN: assert property (!core_clk_en [*2] |-> can_transmit_pin)
      else $error("tx pin dominant in sleep");
   AST_START_CAUSE: assert property (eng_tx_start |-> eng_tx_req && eng_run)
      else $error("start granted without cause");
   AST_NO_SLEEP_OPER: assert property (eng_run && ctl_w && reg_wdata[CTRL_SLEEP_BIT] |=> core_clk_en)
      else $error("sleep entered from operate");
   AST_SLEEP_ENTRY: assert property ($fell(core_clk_en) |-> $past(eng_halted))
      else $error("sleep entered from wrong mode");
   AST_RESUME: assert property (!core_clk_en && ctl_w && !reg_wdata[CTRL_SLEEP_BIT] |=>
      core_clk_en && eng_halted && !eng_run)
      else $error("sleep exit to wrong mode");
   AST_WAKE_HOLD: assert property (wakeup_irq && !wake_w |=> wakeup_irq)
      else $error("wakeup request lost");
   AST_WAKE_CAUSE: assert property ($rose(wakeup_irq) |-> !$past(core_clk_en) || $past(wake_w))
      else $error("wakeup raised while awake");
   AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == DATA_ZERO)
      else $error("read data outside its cycle");
endmodule
bind canmd_top canmd_sva i_canmd_sva (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .can_transmit_pin(can_transmit_pin), .eng_tx_req(eng_tx_req), .eng_tx_start(eng_tx_start),
   .eng_run(eng_run), .eng_halted(eng_halted), .core_clk_en(core_clk_en), .wakeup_irq(wakeup_irq));

// *** bench/canmd_xcvr.sv ***
// transceiver and bus: wired-and of our pin and the other nodes
`timescale 1ns/1ps
module canmd_xcvr (
   input wire logic txd, // channel transmit pin
   input wire logic other_dom, // another node drives dominant
   output logic rxd // receive pin to the channel
);
   assign rxd = txd & ~other_dom;
endmodule

// *** bench/test_canmd_top.sv ***
// self-checking bench for the can mode-control block
`timescale 1ns/1ps
module test_canmd_top;
   import canmd_pkg::*;
   localparam logic [3:0] E_PIN = 4'hA;
   localparam logic [3:0] E_RX = 4'h8;
   localparam logic [3:0] E_ACK = 4'hC;
   localparam logic [3:0] E_ST = 4'hD;
   logic mclk, rst, reg_wr, reg_rd, eng_tx, eng_tx_req, other_dom, can_receive_pin, can_transmit_pin;
   logic eng_rx, eng_tx_start, eng_self_ack, eng_run, eng_halted, core_clk_en, wakeup_irq;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   int bad_count, cmp_count, i, t;
   canmd_top i_canmd_top (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .can_receive_pin(can_receive_pin),
      .can_transmit_pin(can_transmit_pin), .eng_tx(eng_tx), .eng_tx_req(eng_tx_req), .eng_rx(eng_rx),
      .eng_tx_start(eng_tx_start), .eng_self_ack(eng_self_ack), .eng_run(eng_run),
      .eng_halted(eng_halted), .core_clk_en(core_clk_en), .wakeup_irq(wakeup_irq));
   canmd_xcvr i_canmd_xcvr (.txd(can_transmit_pin), .other_dom(other_dom), .rxd(can_receive_pin));
   task automatic summarize();
      if (bad_count == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      cmp_count++;
      if (s !== e) begin
         bad_count++;
         $display("unexpected at %0t: saw %h want %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask
   // pin changes need the synchroniser plus a register stage
   task automatic settle();
      repeat (8) @(posedge mclk);
      #1;
   endtask
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   initial begin
      {rst, reg_wr, reg_rd, eng_tx, eng_tx_req, other_dom} = 6'h24;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      #1 chk(can_transmit_pin, RECESSIVE);
      chk(wakeup_irq, 1'b0);
      rd(ADDR_CTRL, 8'h01);
      rd(8'h0C, DATA_ZERO);
      wr(ADDR_CTRL, 8'h19);
      rd(ADDR_CTRL, 8'h01);
      for (t = 0; t < 4; t++) begin
         wr(ADDR_CTRL, 8'h02);
         wr(ADDR_CTRL, {3'h0, t[1:0], 3'h2});
         wr(ADDR_CTRL, {3'h0, t[1:0], 3'h0});
         eng_tx <= 1'b0;
         eng_tx_req <= 1'b1;
         settle();
         chk(can_transmit_pin, E_PIN[t]);
         chk(eng_rx, 1'b0);
         chk(eng_self_ack, E_ACK[t]);
         chk(eng_tx_start, E_ST[t]);
         @(posedge mclk);
         eng_tx <= 1'b1;
         other_dom <= 1'b1;
         settle();
         chk(can_transmit_pin, RECESSIVE);
         chk(eng_rx, E_RX[t]);
         @(posedge mclk);
         eng_tx_req <= 1'b0;
         other_dom <= 1'b0;
      end
      wr(ADDR_CTRL, 8'h04);
      #1 chk(core_clk_en, 1'b1);
      wr(ADDR_CTRL, 8'h02);
      wr(ADDR_CTRL, 8'h02);
      wr(ADDR_WAKE, 8'h01);
      wr(ADDR_CTRL, 8'h06);
      eng_tx_req <= 1'b1;
      #1 chk(core_clk_en, 1'b0);
      chk(eng_tx_start, 1'b0);
      rd(ADDR_CTRL, 8'h06);
      @(posedge mclk);
      other_dom <= 1'b1;
      i = 0;
      while (wakeup_irq !== 1'b1 && i < 20) begin
         @(posedge mclk);
         i++;
      end
      chk(wakeup_irq, 1'b1);
      if (i == 20) summarize();
      other_dom <= 1'b0;
      settle();
      chk(wakeup_irq, 1'b1);
      rd(ADDR_WAKE, 8'h03);
      wr(ADDR_WAKE, 8'h03);
      #1 chk(wakeup_irq, 1'b0);
      // cancel asks for reset, yet the channel must return to halt, where it slept from
      wr(ADDR_CTRL, 8'h01);
      #1 chk(eng_halted & core_clk_en, 1'b1);
      rd(ADDR_CTRL, 8'h02);
      wr(ADDR_CTRL, 8'h01);
      wr(ADDR_WAKE, 8'h00);
      wr(ADDR_CTRL, 8'h05);
      other_dom <= 1'b1;
      settle();
      chk(wakeup_irq, 1'b0);
      rd(ADDR_WAKE, 8'h00);
      rd(ADDR_STAT, 8'h05);
      wr(ADDR_CTRL, 8'h02);
      rd(ADDR_CTRL, 8'h01);
      summarize();
   end
endmodule
